// ### rmcfg_defs.svh
// Offsets, field positions, reset values and timing counts of the modem configuration bank
`ifndef RMCFG_DEFS_SVH
`define RMCFG_DEFS_SVH
// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define RMCFG_ADDR_W          9
`define RMCFG_DATA_W          8
`define RMCFG_NUM_REGS        12
`define RMCFG_OFF_FIRST       9'h107
`define RMCFG_OFF_TICK_DIV    9'h107
`define RMCFG_OFF_WAKE_LEVEL  9'h108
`define RMCFG_OFF_CARRIER_LO  9'h109
`define RMCFG_OFF_CARRIER_MID 9'h10a
`define RMCFG_OFF_CARRIER_HI  9'h10b
`define RMCFG_OFF_RATE_LO     9'h10c
`define RMCFG_OFF_DEV_RATE_HI 9'h10d
`define RMCFG_OFF_TONE_LO     9'h10e
`define RMCFG_OFF_CORR_BW     9'h10f
`define RMCFG_OFF_POST_BW     9'h110
`define RMCFG_OFF_RSVD        9'h111
`define RMCFG_OFF_LOOP_PHASE  9'h112
`define RMCFG_OFF_LAST        9'h112
// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define RMCFG_RESET_VAL       8'h00
`define RMCFG_DEV_HI_MSB      7
`define RMCFG_DEV_HI_LSB      4
`define RMCFG_RATE_HI_MSB     3
`define RMCFG_RATE_HI_LSB     0
`define RMCFG_LOOP_TUNE_MSB   7
`define RMCFG_LOOP_TUNE_LSB   2
`define RMCFG_PHASE_MSB       1
`define RMCFG_PHASE_LSB       0
// -----------------------------------------------------------------
// Scale factors and timing counts
// -----------------------------------------------------------------
`define RMCFG_LEVEL_OFFSET    9'sh06b
`define RMCFG_PFD_HZ          49'h00000018cba80
`define RMCFG_STEP_HZ         19'h00064
`define RMCFG_CLK_HZ_100K     7'h64
`define RMCFG_REF_HZ_100K     7'h0d
`define RMCFG_TICK_PRESCALE   7'h7f
`endif

// ### rmcfg_pkg.sv
// Types shared by the modem configuration bank
package rmcfg_pkg;
   // Listen sequencer states, one-hot
   typedef enum logic [2:0] {
      LS_SLEEP   = 3'b001,
      LS_LISTEN  = 3'b010,
      LS_RECEIVE = 3'b100
   } rmcfg_listen_state_type;
   // Settings that the radio datapath reads
   typedef struct packed {
      logic [23:0] carrier_word;
      logic [32:0] carrier_hz;
      logic [11:0] rate_word;
      logic [18:0] rate_bps;
      logic [11:0] tone_word;
      logic [18:0] tone_hz;
      logic [7:0]  corr_bw;
      logic [1:0]  corr_phase;
      logic [8:0]  post_bw_khz;
      logic        post_bw_valid;
      logic [5:0]  loop_tune;
   } rmcfg_radio_cfg_type;
endpackage

// ### rmcfg_tick_gen.sv
// Listen timer tick: 128 x divider periods of a 6.5 MHz reference
`timescale 1ns/10ps
`include "rmcfg_defs.svh"
module rmcfg_tick_gen (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       run_i,
   input  wire logic [7:0] divider_i,
   output logic            tick_o
);
   logic [6:0] ref_acc_reg;
   logic [6:0] pre_reg;
   logic [7:0] div_reg;
   logic       ref_en;
   logic       pre_wrap;
   logic [7:0] tick_div;

   // Reference enable: 13 of every 100 cycles gives 6.5 MHz
   assign ref_en   = (ref_acc_reg + `RMCFG_REF_HZ_100K) >= `RMCFG_CLK_HZ_100K;
   assign pre_wrap = ref_en && (pre_reg == `RMCFG_TICK_PRESCALE);
   assign tick_div = divider_i - 8'h01;

   // Fractional accumulator, runs freely
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ref_acc_reg <= 7'h00;
      end else if (ref_en) begin
         ref_acc_reg <= ref_acc_reg + `RMCFG_REF_HZ_100K - `RMCFG_CLK_HZ_100K;
      end else begin
         ref_acc_reg <= ref_acc_reg + `RMCFG_REF_HZ_100K;
      end
   end

   // Prescale by 128 and divide by divider; restarts when idle
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pre_reg <= 7'h00;
         div_reg <= 8'h00;
         tick_o  <= 1'b0;
      end else if (!run_i || divider_i == 8'h00) begin
         pre_reg <= 7'h00;
         div_reg <= 8'h00;
         tick_o  <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (ref_en) begin
            pre_reg <= pre_reg + 7'h01;
         end
         if (pre_wrap) begin
            if (div_reg >= tick_div) begin
               div_reg <= 8'h00;
               tick_o  <= 1'b1;  // [R01]
            end else begin
               div_reg <= div_reg + 8'h01;
            end
         end
      end
   end
endmodule // rmcfg_tick_gen

// ### rmcfg_dwell_timer.sv
// Counts listen ticks and flags the end of the listen period
`timescale 1ns/10ps
module rmcfg_dwell_timer (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       clear_i,
   input  wire logic       tick_i,
   input  wire logic [7:0] period_i,
   output logic            expired_o
);
   logic [7:0] count_reg;

   // Expired once the tick count reaches the period
   assign expired_o = tick_i && ((count_reg + 8'h01) >= period_i);

   // Tick counter
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_reg <= 8'h00;
      end else if (clear_i) begin
         count_reg <= 8'h00;
      end else if (tick_i && count_reg != 8'hff) begin
         count_reg <= count_reg + 8'h01;  // [R02]
      end
   end
endmodule // rmcfg_dwell_timer

// ### rmcfg_bank.sv
// Modem configuration register bank with listen sequencer and derived settings
// Summary of operation
// [R01] Listen tick is 128 x divider at 6.5 MHz
// [R02] Wake fire powers receiver for dwell ticks
// [R03] Wake level threshold is register minus 107
// [R04] Carrier word low first, 26 MHz x word/65536
// [R05] Rate word times 100 gives bits per second
// [R06] Deviation word high nibble; times 100 hertz
// [R07] Correlator bandwidth byte drives the demodulator
// [R08] Post filter kHz is twice value, 1..255
// [R09] Loop tuning used only for selection 1, 3
// [R10] Low two bits set correlator phase
// [R11] Selection 0 loads default tables on entry
// [R12] Byte registers read back last write, no effects
`timescale 1ns/10ps
`include "rmcfg_defs.svh"
module rmcfg_bank (
   input  wire logic                        clk_i,
   input  wire logic                        reset_n_i,
   // Register port
   input  wire logic [8:0]                  reg_addr_i,
   input  wire logic [7:0]                  reg_wdata_i,
   input  wire logic                        reg_write_i,
   input  wire logic                        reg_read_i,
   output logic [7:0]                       reg_rdata_o,
   // Autonomous listen control
   input  wire logic                        listen_mode_en_i,
   input  wire logic                        level_detect_en_i,
   input  wire logic                        wake_fire_i,
   input  wire logic [7:0]                  dwell_ticks_i,
   input  wire logic                        preamble_found_i,
   input  wire logic                        receive_done_i,
   input  wire logic signed [8:0]           signal_level_dbm_i,
   output logic                             receiver_power_o,
   output logic                             listen_expired_o,
   output logic                             level_above_o,
   output logic signed [8:0]                wake_level_dbm_o,
   // Loop table handling
   input  wire logic [1:0]                  loop_table_selection_i,
   input  wire logic                        radio_tx_i,
   input  wire logic                        radio_rx_i,
   output logic                             load_tx_table_o,
   output logic                             load_rx_table_o,
   // Settings for the radio datapath
   output rmcfg_pkg::rmcfg_radio_cfg_type   radio_cfg_o
);
   import rmcfg_pkg::*;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [7:0]             cfg_reg [`RMCFG_NUM_REGS];
   logic [3:0]             wr_index;
   logic                   wr_hit;
   logic [3:0]             rd_index;
   logic                   rd_hit;
   rmcfg_listen_state_type state_reg;
   rmcfg_listen_state_type state_next;
   logic                   listen_tick;
   logic                   dwell_expired;
   logic                   dwell_clear;
   logic                   preamble_ok;
   logic                   radio_tx_reg;
   logic                   radio_rx_reg;
   logic [23:0]            carrier_word;
   logic [11:0]            rate_word;
   logic [11:0]            tone_word;
   logic [48:0]            carrier_product;
   logic [18:0]            rate_product;
   logic [18:0]            tone_product;
   logic signed [8:0]      level_threshold;

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------

   // Maps a byte offset to its slot; hit is low outside the bank
   function automatic logic [4:0] decode_slot(input logic [8:0] addr);
      logic [8:0] rel;
      rel = addr - `RMCFG_OFF_FIRST;
      if (addr >= `RMCFG_OFF_FIRST && addr <= `RMCFG_OFF_LAST) begin
         decode_slot = {1'b1, rel[3:0]};
      end else begin
         decode_slot = 5'h00;
      end
   endfunction

   // Write and read decode
   assign {wr_hit, wr_index} = decode_slot(reg_addr_i);
   assign {rd_hit, rd_index} = decode_slot(reg_addr_i);

   // -----------------------------------------------------------------
   // Register storage
   // -----------------------------------------------------------------

   // One byte register per slot, written only when addressed
   generate
      for (genvar g = 0; g < `RMCFG_NUM_REGS; g++) begin : g_cfg
         always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               cfg_reg[g] <= `RMCFG_RESET_VAL;
            end else if (reg_write_i && wr_hit && wr_index == 4'(g)) begin
               cfg_reg[g] <= reg_wdata_i;  // [R12]
            end
         end
      end
   endgenerate

   // Read data one cycle after the strobe, zero when unmapped
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_read_i && rd_hit) begin
         reg_rdata_o <= cfg_reg[rd_index];  // [R12]
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // -----------------------------------------------------------------
   // Word assembly
   // -----------------------------------------------------------------

   // Carrier word, low byte first
   assign carrier_word = {cfg_reg[4], cfg_reg[3], cfg_reg[2]};  // [R04]

   // Rate word: full low byte plus low nibble of shared byte
   assign rate_word = {cfg_reg[6][`RMCFG_RATE_HI_MSB:`RMCFG_RATE_HI_LSB],
                       cfg_reg[5]};  // [R05]

   // Deviation word: high nibble of shared byte on top
   assign tone_word = {cfg_reg[6][`RMCFG_DEV_HI_MSB:`RMCFG_DEV_HI_LSB],
                       cfg_reg[7]};  // [R06]

   // Scaled values
   assign carrier_product = 49'(carrier_word) * `RMCFG_PFD_HZ;  // [R04]
   assign rate_product    = 19'(rate_word) * `RMCFG_STEP_HZ;     // [R05]
   assign tone_product    = 19'(tone_word) * `RMCFG_STEP_HZ;     // [R06]

   // Threshold in dBm, register less the fixed offset
   assign level_threshold = $signed({1'b0, cfg_reg[1]}) - `RMCFG_LEVEL_OFFSET;  // [R03]

   // -----------------------------------------------------------------
   // Settings to the datapath
   // -----------------------------------------------------------------

   // Registered copies of the derived settings
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         radio_cfg_o <= '0;
      end else begin
         radio_cfg_o.carrier_word  <= carrier_word;
         radio_cfg_o.carrier_hz    <= carrier_product[48:16];  // [R04]
         radio_cfg_o.rate_word     <= rate_word;
         radio_cfg_o.rate_bps      <= rate_product;  // [R05]
         radio_cfg_o.tone_word     <= tone_word;
         radio_cfg_o.tone_hz       <= tone_product;  // [R06]
         radio_cfg_o.corr_bw       <= cfg_reg[8];  // [R07]
         radio_cfg_o.corr_phase    <= cfg_reg[11][`RMCFG_PHASE_MSB:`RMCFG_PHASE_LSB];  // [R10]
         radio_cfg_o.post_bw_khz   <= {cfg_reg[9], 1'b0};  // [R08]
         radio_cfg_o.post_bw_valid <= cfg_reg[9] != 8'h00;  // [R08]
         // Loop tuning only passes for selection 1 or 3; kept here so the struct has one driver
         radio_cfg_o.loop_tune     <= loop_table_selection_i[0] ?
                                      cfg_reg[11][`RMCFG_LOOP_TUNE_MSB:`RMCFG_LOOP_TUNE_LSB] : 6'h00;  // [R09]
      end
   end

   // Threshold shown to the datapath
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wake_level_dbm_o <= 9'sh000;
      end else begin
         wake_level_dbm_o <= level_threshold;  // [R03]
      end
   end

   // -----------------------------------------------------------------
   // Loop table loading
   // -----------------------------------------------------------------

   // Previous transmit and receive state levels
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         radio_tx_reg <= 1'b0;
         radio_rx_reg <= 1'b0;
      end else begin
         radio_tx_reg <= radio_tx_i;
         radio_rx_reg <= radio_rx_i;
      end
   end

   // Pulse on entry to transmit or receive with selection 0
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         load_tx_table_o <= 1'b0;
         load_rx_table_o <= 1'b0;
      end else begin
         load_tx_table_o <= radio_tx_i && !radio_tx_reg &&
                            loop_table_selection_i == 2'h0;  // [R11]
         load_rx_table_o <= radio_rx_i && !radio_rx_reg &&
                            loop_table_selection_i == 2'h0;  // [R11]
      end
   end

   // -----------------------------------------------------------------
   // Listen timing
   // -----------------------------------------------------------------

   // Tick source runs only while listening
   rmcfg_tick_gen u_tick (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .run_i     (state_reg == LS_LISTEN),
      .divider_i (cfg_reg[0]),
      .tick_o    (listen_tick)
   );

   // Listen period counter
   rmcfg_dwell_timer u_dwell (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .clear_i   (dwell_clear),
      .tick_i    (listen_tick),
      .period_i  (dwell_ticks_i),
      .expired_o (dwell_expired)
   );

   // Counter restarts whenever not listening
   assign dwell_clear = state_reg != LS_LISTEN;

   // Preamble counts only at or above the level threshold when enabled
   assign preamble_ok = preamble_found_i &&
                        (!level_detect_en_i || signal_level_dbm_i >= level_threshold);  // [R03]

   // -----------------------------------------------------------------
   // Listen sequencer
   // -----------------------------------------------------------------

   // Next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         LS_SLEEP: begin
            if (wake_fire_i && listen_mode_en_i) begin
               state_next = LS_LISTEN;  // [R02]
            end
         end
         LS_LISTEN: begin
            if (preamble_ok) begin
               state_next = LS_RECEIVE;
            end else if (dwell_expired || dwell_ticks_i == 8'h00) begin
               state_next = LS_SLEEP;  // [R02]
            end
         end
         LS_RECEIVE: begin
            if (receive_done_i) begin
               state_next = LS_SLEEP;
            end
         end
         default: begin
            state_next = LS_SLEEP;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= LS_SLEEP;
      end else begin
         state_reg <= state_next;
      end
   end

   // Receiver power and expiry pulse
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         receiver_power_o <= 1'b0;
         listen_expired_o <= 1'b0;
      end else begin
         receiver_power_o <= state_next != LS_SLEEP;  // [R02]
         listen_expired_o <= state_reg == LS_LISTEN && state_next == LS_SLEEP;
      end
   end

   // Level comparison while listening with detection on
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         level_above_o <= 1'b0;
      end else begin
         level_above_o <= level_detect_en_i && state_reg == LS_LISTEN &&
                          signal_level_dbm_i >= level_threshold;  // [R03]
      end
   end
endmodule // rmcfg_bank

// ### rmcfg_monitor.sv
// Port checker for the modem configuration bank, bound to the bank
`timescale 1ns/10ps
module rmcfg_monitor (
   input  wire logic                          clk_i,
   input  wire logic                          reset_n_i,
   input  wire logic [8:0]                    reg_addr_i,
   input  wire logic                          reg_read_i,
   input  wire logic [7:0]                    reg_rdata_o,
   input  wire logic                          listen_mode_en_i,
   input  wire logic                          wake_fire_i,
   input  wire logic                          receiver_power_o,
   input  wire logic                          listen_expired_o,
   input  wire logic                          level_above_o,
   input  wire logic signed [8:0]             wake_level_dbm_o,
   input  wire logic [1:0]                    loop_table_selection_i,
   input  wire logic                          radio_tx_i,
   input  wire logic                          radio_rx_i,
   input  wire logic                          load_tx_table_o,
   input  wire logic                          load_rx_table_o,
   input  wire rmcfg_pkg::rmcfg_radio_cfg_type radio_cfg_o
);
   import rmcfg_pkg::*;
   default clocking mon_cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // Register readback and derived settings
   a_rdata_stands: assert property (
      reg_rdata_o != 8'h00 |-> $past(reg_read_i)) else $error("read data outside its cycle");
   a_wake_level_math: assert property (
      reg_read_i && reg_addr_i == 9'h108 |=> wake_level_dbm_o == $signed({1'b0, reg_rdata_o}) - 9'sd107)
      else $error("wake level threshold wrong");
   a_carrier_scale: assert property (
      radio_cfg_o.carrier_hz == 33'((64'(radio_cfg_o.carrier_word) * 64'd26000000) >> 16))
      else $error("carrier frequency scale wrong");
   a_rate_scale: assert property (
      radio_cfg_o.rate_bps == 19'(radio_cfg_o.rate_word * 19'd100)) else $error("bit rate scale wrong");
   a_tone_scale: assert property (
      radio_cfg_o.tone_hz == 19'(radio_cfg_o.tone_word * 19'd100)) else $error("tone offset scale wrong");
   a_corr_bw_copy: assert property (
      reg_read_i && reg_addr_i == 9'h10f |=> radio_cfg_o.corr_bw == reg_rdata_o) else $error("bandwidth wrong");
   a_post_filter: assert property (
      !radio_cfg_o.post_bw_khz[0] && radio_cfg_o.post_bw_valid == (radio_cfg_o.post_bw_khz != 9'h000))
      else $error("post filter width wrong");
   a_loop_phase: assert property (
      reg_read_i && reg_addr_i == 9'h112 && loop_table_selection_i[0] |=>
      radio_cfg_o.corr_phase == reg_rdata_o[1:0] && radio_cfg_o.loop_tune == reg_rdata_o[7:2])
      else $error("loop tuning or phase wrong");
   a_loop_gated: assert property (
      !$past(loop_table_selection_i[0]) |-> radio_cfg_o.loop_tune == 6'h00) else $error("loop tuning not gated");
   // Listen sequencing and table loads
   a_wake_power: assert property (
      wake_fire_i && listen_mode_en_i && !receiver_power_o |=> receiver_power_o) else $error("receiver not on");
   a_expire_off: assert property (
      listen_expired_o |-> !receiver_power_o ##1 !listen_expired_o) else $error("expiry pulse wrong");
   a_rx_table: assert property (
      $rose(radio_rx_i) && loop_table_selection_i == 2'h0 |=> load_rx_table_o) else $error("rx table missed");
   a_tx_table_cause: assert property (
      load_tx_table_o |-> $past(loop_table_selection_i) == 2'h0 && $past(radio_tx_i))
      else $error("tx table load without cause");
   c_expired: cover property (listen_expired_o);
   c_rx_load: cover property (load_rx_table_o);
   c_level_above: cover property (level_above_o);
endmodule // rmcfg_monitor

bind rmcfg_bank rmcfg_monitor u_monitor (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
   .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .listen_mode_en_i(listen_mode_en_i),
   .wake_fire_i(wake_fire_i), .receiver_power_o(receiver_power_o), .listen_expired_o(listen_expired_o),
   .level_above_o(level_above_o), .wake_level_dbm_o(wake_level_dbm_o),
   .loop_table_selection_i(loop_table_selection_i), .radio_tx_i(radio_tx_i), .radio_rx_i(radio_rx_i),
   .load_tx_table_o(load_tx_table_o), .load_rx_table_o(load_rx_table_o), .radio_cfg_o(radio_cfg_o));

// ### rmcfg_tb.sv
// Self-checking testbench for the modem configuration bank
`timescale 1ns/10ps
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("Error %s expected %0h seen %0h", what, exp, got); end end
module testbench;
   import rmcfg_pkg::*;
   logic              clk_i = 1'b0, reset_n_i = 1'b0, reg_write_i = 1'b0, reg_read_i = 1'b0;
   logic              listen_mode_en_i = 1'b0, level_detect_en_i = 1'b0, wake_fire_i = 1'b0;
   logic              preamble_found_i = 1'b0, receive_done_i = 1'b0, radio_tx_i = 1'b0, radio_rx_i = 1'b0;
   logic [8:0]        reg_addr_i = 9'h000;
   logic [7:0]        reg_wdata_i = 8'h00, dwell_ticks_i = 8'h00, reg_rdata_o;
   logic signed [8:0] signal_level_dbm_i = 9'sh000, wake_level_dbm_o;
   logic [1:0]        loop_table_selection_i = 2'h0;
   logic              receiver_power_o, listen_expired_o, level_above_o, load_tx_table_o, load_rx_table_o;
   rmcfg_radio_cfg_type radio_cfg_o;
   int                error_cnt = 0, n_checks = 0;
   // Free-running 50 MHz clock
   always #10 clk_i = ~clk_i;
   rmcfg_bank DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
      .listen_mode_en_i(listen_mode_en_i), .level_detect_en_i(level_detect_en_i), .wake_fire_i(wake_fire_i),
      .dwell_ticks_i(dwell_ticks_i), .preamble_found_i(preamble_found_i), .receive_done_i(receive_done_i),
      .signal_level_dbm_i(signal_level_dbm_i), .receiver_power_o(receiver_power_o),
      .listen_expired_o(listen_expired_o), .level_above_o(level_above_o), .wake_level_dbm_o(wake_level_dbm_o),
      .loop_table_selection_i(loop_table_selection_i), .radio_tx_i(radio_tx_i), .radio_rx_i(radio_rx_i),
      .load_tx_table_o(load_tx_table_o), .load_rx_table_o(load_rx_table_o), .radio_cfg_o(radio_cfg_o));
   // One-cycle register write
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clk_i);
      reg_write_i <= 1'b0;
   endtask
   // One-cycle register read, data taken in the following cycle
   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clk_i);
      reg_read_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   // Let derived settings catch up with a write
   task automatic settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   // Wake the receiver and confirm it powers up
   task automatic fire;
      @(posedge clk_i);
      wake_fire_i <= 1'b1;
      @(posedge clk_i);
      wake_fire_i <= 1'b0;
      #1 `CHK("receiver power on", 1'b1, receiver_power_o)
   endtask
   task automatic t_regs;
      logic [7:0] d;
      for (int i = 0; i < 12; i++) begin
         rd(9'h107 + 9'(i), d);
         `CHK("reset value", 8'h00, d)
         wr(9'h107 + 9'(i), 8'(i) ^ 8'ha5);
      end
      for (int i = 0; i < 12; i++) begin
         rd(9'h107 + 9'(i), d);
         `CHK("readback", 8'(i) ^ 8'ha5, d)
      end
      @(posedge clk_i);
      #1 `CHK("read data hold", 8'h00, reg_rdata_o)
      wr(9'h113, 8'hff);
      rd(9'h113, d);
      `CHK("unmapped read", 8'h00, d)
      $display("test registers done");
   endtask
   task automatic t_fields;
      logic [7:0] d;
      wr(9'h109, 8'h56);
      wr(9'h10a, 8'h34);
      wr(9'h10b, 8'h12);
      wr(9'h10c, 8'hab);
      wr(9'h10d, 8'h9c);
      wr(9'h10e, 8'h78);
      wr(9'h10f, 8'h5a);
      wr(9'h110, 8'hff);
      wr(9'h112, 8'hb7);
      loop_table_selection_i <= 2'h1;
      settle;
      `CHK("carrier word", 24'h123456, radio_cfg_o.carrier_word)
      `CHK("carrier hz", 33'((64'h123456 * 64'd26000000) >> 16), radio_cfg_o.carrier_hz)
      `CHK("rate word", 12'hcab, radio_cfg_o.rate_word)
      `CHK("rate bps", 19'(12'hcab * 100), radio_cfg_o.rate_bps)
      `CHK("tone word", 12'h978, radio_cfg_o.tone_word)
      `CHK("tone hz", 19'(12'h978 * 100), radio_cfg_o.tone_hz)
      `CHK("corr bw", 8'h5a, radio_cfg_o.corr_bw)
      `CHK("corr phase", 2'h3, radio_cfg_o.corr_phase)
      `CHK("post bw", 9'h1fe, radio_cfg_o.post_bw_khz)
      `CHK("post bw valid", 1'b1, radio_cfg_o.post_bw_valid)
      `CHK("loop tune", 6'h2d, radio_cfg_o.loop_tune)
      rd(9'h112, d);
      `CHK("loop reg readback", 8'hb7, d)
      loop_table_selection_i <= 2'h2;
      wr(9'h110, 8'h00);
      settle;
      `CHK("loop tune gated", 6'h00, radio_cfg_o.loop_tune)
      `CHK("post bw zero", 1'b0, radio_cfg_o.post_bw_valid)
      $display("test fields done");
   endtask
   task automatic t_listen;
      int n;
      wr(9'h108, 8'h00);
      settle;
      `CHK("level floor", 9'h195, wake_level_dbm_o)
      wr(9'h108, 8'hff);
      settle;
      `CHK("level ceiling", 9'h094, wake_level_dbm_o)
      wr(9'h108, 8'h20);
      wr(9'h107, 8'h01);
      dwell_ticks_i <= 8'h02;
      listen_mode_en_i <= 1'b1;
      level_detect_en_i <= 1'b1;
      signal_level_dbm_i <= -9'sd75;
      fire;
      repeat (3) @(posedge clk_i);
      signal_level_dbm_i <= -9'sd76;
      #1 `CHK("level at limit", 1'b1, level_above_o)
      repeat (3) @(posedge clk_i);
      #1 `CHK("level below limit", 1'b0, level_above_o)
      n = 6;
      while (listen_expired_o !== 1'b1 && n < 3000) begin
         @(posedge clk_i);
         #1 n++;
      end
      `CHK("dwell span", 1'b1, n >= 1960 && n <= 1975)
      `CHK("power after dwell", 1'b0, receiver_power_o)
      level_detect_en_i <= 1'b0;
      fire;
      preamble_found_i <= 1'b1;
      @(posedge clk_i);
      preamble_found_i <= 1'b0;
      n = 0;
      repeat (2200) begin
         @(posedge clk_i);
         #1 n += int'(listen_expired_o !== 1'b0);
      end
      `CHK("no expiry in receive", 0, n)
      `CHK("power in receive", 1'b1, receiver_power_o)
      receive_done_i <= 1'b1;
      @(posedge clk_i);
      receive_done_i <= 1'b0;
      settle;
      `CHK("power after receive", 1'b0, receiver_power_o)
      $display("test listen done");
   endtask
   task automatic t_tables;
      for (int s = 0; s < 4; s++) begin
         @(posedge clk_i);
         loop_table_selection_i <= 2'(s);
         radio_rx_i <= 1'b1;
         @(posedge clk_i);
         radio_rx_i <= 1'b0;
         #1 `CHK("rx table load", 1'(s == 0), load_rx_table_o)
         @(posedge clk_i);
         radio_tx_i <= 1'b1;
         @(posedge clk_i);
         radio_tx_i <= 1'b0;
         #1 `CHK("tx table load", 1'(s == 0), load_tx_table_o)
      end
      $display("test tables done");
   endtask
   // Counts and verdict, then stop
   task automatic results;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Main sequence after an 8-cycle reset
   initial begin
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_regs;
      t_fields;
      t_listen;
      t_tables;
      results;
   end
   // Watchdog well beyond the expected run
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      results;
   end
endmodule // testbench
